// >>> common/pbs_defs.vh
`ifndef PBS_DEFS_VH
`define PBS_DEFS_VH

// Pin widths, 36-bit organisation
`define PBS_ADDR_W 18
`define PBS_DATA_W 36
`define PBS_LANES 4
`define PBS_LANE_W 9

// Storage depth held in flip-flops; upper address bits alias
`define PBS_MEM_AW 5
`define PBS_MEM_DEPTH 32

// Write buffer
`define PBS_FIFO_DEPTH 8
`define PBS_FIFO_AW 3
`define PBS_FIFO_CW 4

// Buffer entry layout: {address, lane enables (low active), data}
`define PBS_ENT_DATA_LSB 0
`define PBS_ENT_LANE_LSB 36
`define PBS_ENT_ADDR_LSB 40
`define PBS_ENTRY_W 58

// Reset values
`define PBS_MODE_RESET 1'b1
`define PBS_LANES_RESET 4'hF
`define PBS_DATA_RESET 36'h0
`define PBS_ADDR_RESET 18'h0

// Pipeline depth from address sample to data on the bus
`define PBS_DATA_LATENCY 2

`endif

// >>> rtl/pbs_fifo.v
`timescale 1ns/1ps
`include "pbs_defs.vh"

module pbs_fifo #(
   parameter WIDTH = `PBS_ENTRY_W,
   parameter DEPTH = `PBS_FIFO_DEPTH,
   parameter AW = `PBS_FIFO_AW,
   parameter CW = `PBS_FIFO_CW
) (
   input wire ref_clk,
   input wire rst_b,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [WIDTH*DEPTH-1:0] store_flat,
   output wire [AW-1:0] head_idx,
   output wire [CW-1:0] fill_count
);

reg [AW-1:0] wr_ptr_q;
reg [AW-1:0] rd_ptr_q;
reg [CW-1:0] count_q;
wire push;
wire pop;

assign in_ready = (count_q != DEPTH[CW-1:0]);
assign out_valid = (count_q != {CW{1'b0}});
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;
assign out_data = store_flat[rd_ptr_q*WIDTH +: WIDTH];
assign head_idx = rd_ptr_q;
assign fill_count = count_q;

genvar g;
generate
   for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
      localparam [AW-1:0] SLOT = g;
      reg [WIDTH-1:0] slot_q;
      assign store_flat[g*WIDTH +: WIDTH] = slot_q;
      // Payload needs no reset; count gates every use of it
      always @(posedge ref_clk) begin
         if (push && wr_ptr_q == SLOT) begin
            slot_q <= in_data;
         end
      end
   end
endgenerate

always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {CW{1'b0}};
   end else begin
      if (push) begin
         wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
         rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
         count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
      end else if (pop && !push) begin
         count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
      end
   end
end

endmodule // pbs_fifo

// >>> rtl/pbs_sram_port.v
`timescale 1ns/1ps
`include "pbs_defs.vh"

// Overview of operation
// RL1 - A burst steps the two low address bits through four words in the order the burst-order pin picks, reads and writes alike.
// RL2 - Sampling load/advance low ends any running burst and loads a fresh address and control set on that edge.
// RL3 - Read or write is fixed by the read/write pin at load time and that pin is ignored while advancing.
// RL4 - A write cycle starts when read/write and load/advance are both sampled low on the same rising edge.
// RL5 - The controller keeps the byte-lane qualifiers valid on every write cycle and every advancing write beat.
// RL6 - Byte-lane qualifiers come one cycle ahead of their beat's data and the device delays them to line up.
// RL7 - Lanes three and four exist only in the 36-bit organisation, the 18-bit one having just two lanes.
// RL8 - The device is selected only when chip select one and three are low and chip select two is high.
// RL9 - An edge with the clock gate sampled high is treated as absent and every register holds its state.
// RL10 - Any chip select sampled inactive starts a deselect cycle and the data bus then goes to high impedance.
// RL11 - Read data is driven, and write data is taken, two cycles after its address and control were sampled.
// RL12 - Burst-order high XORs the count with the start bits, low adds the count modulo four.
module pbs_sram_port (
   input wire ref_clk,
   input wire rst_b,
   input wire [`PBS_ADDR_W-1:0] addr,
   input wire chip_select_one_n,
   input wire chip_select_two,
   input wire chip_select_three_n,
   input wire load_or_advance_n,
   input wire write_enable_n,
   input wire [`PBS_LANES-1:0] byte_lane_write_n,
   input wire clock_gate_n,
   input wire burst_order_interleaved,
   input wire [`PBS_DATA_W-1:0] dq_in,
   output wire [`PBS_DATA_W-1:0] dq_out,
   output wire dq_oe,
   output wire write_buffer_ready
);

localparam ST_IDLE = 2'b00;
localparam ST_READ = 2'b01;
localparam ST_WRITE = 2'b10;

// Burst state
reg [1:0] state_q;
reg [1:0] state_d;
reg [`PBS_ADDR_W-1:0] base_addr_q;
reg [`PBS_ADDR_W-1:0] base_addr_d;
reg [1:0] start_q;
reg [1:0] start_d;
reg [1:0] count_q;
reg [1:0] count_d;
reg beat_valid;
reg beat_write;
reg [`PBS_ADDR_W-1:0] beat_addr;

// Pipeline stages
reg s1_valid_q;
reg s1_write_q;
reg [`PBS_ADDR_W-1:0] s1_addr_q;
reg s2_valid_q;
reg s2_write_q;
reg [`PBS_ADDR_W-1:0] s2_addr_q;
reg [`PBS_LANES-1:0] s2_lanes_q;

// Output drive
reg [`PBS_DATA_W-1:0] dq_out_q;
reg dq_oe_q;

// Mode strap synchroniser
reg mode_meta_q;
reg mode_sync_q;

// Read lookup
reg [`PBS_DATA_W-1:0] rd_word;
reg [`PBS_FIFO_AW-1:0] fwd_idx;
reg [`PBS_ENTRY_W-1:0] fwd_ent;
integer k;
integer l;

wire clk_run;
wire selected;
wire load_cycle;
wire s2_read;
wire push_valid;
wire [`PBS_ENTRY_W-1:0] push_ent;
wire drain_valid;
wire drain_ready;
wire [`PBS_ENTRY_W-1:0] drain_ent;
wire [`PBS_ENTRY_W*`PBS_FIFO_DEPTH-1:0] fifo_flat;
wire [`PBS_FIFO_AW-1:0] fifo_head;
wire [`PBS_FIFO_CW-1:0] fifo_count;
wire [`PBS_MEM_AW-1:0] drain_idx;
wire [`PBS_MEM_AW-1:0] rd_idx;
wire [`PBS_DATA_W-1:0] array_rd;
wire [1:0] burst_bits;
wire burst_bit_low;
wire burst_bit_high;

assign clk_run = ~clock_gate_n; // RL9
assign selected = ~chip_select_one_n & chip_select_two & ~chip_select_three_n; // RL8
assign load_cycle = ~load_or_advance_n;
assign s2_read = s2_valid_q & ~s2_write_q;

// Next word in the burst; count already stepped
function [1:0] burst_step;
   input [1:0] start;
   input [1:0] cnt;
   input interleave;
   begin
      if (interleave) begin
         burst_step = start ^ cnt; // RL12
      end else begin
         burst_step = start + cnt; // RL12
      end
   end
endfunction

assign burst_bits = burst_step(start_q, count_q + 2'b01, mode_sync_q); // RL1
assign burst_bit_low = burst_bits[0];
assign burst_bit_high = burst_bits[1];

// Static strap from a pin, so it is synchronised; held while the clock is gated
always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      mode_meta_q <= `PBS_MODE_RESET;
      mode_sync_q <= `PBS_MODE_RESET;
   end else if (clk_run) begin // RL9
      mode_meta_q <= burst_order_interleaved;
      mode_sync_q <= mode_meta_q;
   end
end

always @* begin
   state_d = state_q;
   base_addr_d = base_addr_q;
   start_d = start_q;
   count_d = count_q;
   beat_valid = 1'b0;
   beat_write = 1'b0;
   beat_addr = base_addr_q;
   if (!selected) begin
      state_d = ST_IDLE; // RL10
   end else if (load_cycle) begin
      base_addr_d = addr; // RL2
      start_d = addr[1:0];
      count_d = 2'b00;
      beat_valid = 1'b1;
      beat_write = ~write_enable_n; // RL4
      beat_addr = addr;
      if (write_enable_n) begin
         state_d = ST_READ; // RL3
      end else begin
         state_d = ST_WRITE; // RL3
      end
   end else begin
      case (state_q)
         ST_IDLE: begin
            state_d = ST_IDLE;
         end
         ST_READ, ST_WRITE: begin
            // Read/write pin is not looked at here
            count_d = count_q + 2'b01; // RL1
            beat_valid = 1'b1;
            beat_write = (state_q == ST_WRITE); // RL3
            beat_addr = {base_addr_q[`PBS_ADDR_W-1:2], burst_bit_high, burst_bit_low}; // RL1
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end
end

always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      state_q <= ST_IDLE;
      base_addr_q <= `PBS_ADDR_RESET;
      start_q <= 2'b00;
      count_q <= 2'b00;
   end else if (clk_run) begin // RL9
      state_q <= state_d;
      base_addr_q <= base_addr_d;
      start_q <= start_d;
      count_q <= count_d;
   end
end

// Two-stage pipe; lanes enter one edge after the address
always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      s1_valid_q <= 1'b0;
      s1_write_q <= 1'b0;
      s1_addr_q <= `PBS_ADDR_RESET;
      s2_valid_q <= 1'b0;
      s2_write_q <= 1'b0;
      s2_addr_q <= `PBS_ADDR_RESET;
      s2_lanes_q <= `PBS_LANES_RESET;
   end else if (clk_run) begin // RL9
      s1_valid_q <= beat_valid;
      s1_write_q <= beat_write;
      s1_addr_q <= beat_addr;
      s2_valid_q <= s1_valid_q; // RL11
      s2_write_q <= s1_write_q;
      s2_addr_q <= s1_addr_q;
      s2_lanes_q <= byte_lane_write_n; // RL6
   end
end

// Write beat: data taken on the second edge after its address
assign push_valid = clk_run & s2_valid_q & s2_write_q; // RL11
assign push_ent = {s2_addr_q, s2_lanes_q, dq_in}; // RL6

// Array is modelled single ported, so a read cycle stalls the drain
assign drain_ready = clk_run & ~s2_read;

pbs_fifo #(
   .WIDTH(`PBS_ENTRY_W),
   .DEPTH(`PBS_FIFO_DEPTH),
   .AW(`PBS_FIFO_AW),
   .CW(`PBS_FIFO_CW)
) u_wr_buf (
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .in_valid(push_valid),
   .in_ready(write_buffer_ready),
   .in_data(push_ent),
   .out_valid(drain_valid),
   .out_ready(drain_ready),
   .out_data(drain_ent),
   .store_flat(fifo_flat),
   .head_idx(fifo_head),
   .fill_count(fifo_count)
);

assign drain_idx = drain_ent[`PBS_ENT_ADDR_LSB +: `PBS_MEM_AW];
assign rd_idx = s2_addr_q[`PBS_MEM_AW-1:0];

// One storage column per byte lane; a lane writes only if its enable was low
genvar g;
generate
   for (g = 0; g < `PBS_LANES; g = g + 1) begin : g_lane
      reg [`PBS_LANE_W-1:0] lane_mem_q [0:`PBS_MEM_DEPTH-1];
      assign array_rd[g*`PBS_LANE_W +: `PBS_LANE_W] = lane_mem_q[rd_idx];
      always @(posedge ref_clk) begin
         if (drain_valid && drain_ready && !drain_ent[`PBS_ENT_LANE_LSB + g]) begin // RL7
            lane_mem_q[drain_idx] <= drain_ent[g*`PBS_LANE_W +: `PBS_LANE_W];
         end
      end
   end
endgenerate

// Pending writes overlay the array, oldest first, so the newest byte wins
always @* begin
   rd_word = array_rd;
   fwd_idx = {`PBS_FIFO_AW{1'b0}};
   fwd_ent = {`PBS_ENTRY_W{1'b0}};
   for (k = 0; k < `PBS_FIFO_DEPTH; k = k + 1) begin
      fwd_idx = fifo_head + k[`PBS_FIFO_AW-1:0];
      fwd_ent = fifo_flat[fwd_idx*`PBS_ENTRY_W +: `PBS_ENTRY_W];
      if ((k[`PBS_FIFO_CW-1:0] < fifo_count) &&
          (fwd_ent[`PBS_ENT_ADDR_LSB +: `PBS_MEM_AW] == rd_idx)) begin
         for (l = 0; l < `PBS_LANES; l = l + 1) begin
            if (!fwd_ent[`PBS_ENT_LANE_LSB + l]) begin
               rd_word[l*`PBS_LANE_W +: `PBS_LANE_W] = fwd_ent[l*`PBS_LANE_W +: `PBS_LANE_W];
            end
         end
      end
   end
end

// Bus drive; released after write beats and deselects alike
always @(posedge ref_clk or negedge rst_b) begin
   if (!rst_b) begin
      dq_out_q <= `PBS_DATA_RESET;
      dq_oe_q <= 1'b0;
   end else if (clk_run) begin // RL9
      dq_oe_q <= s2_read; // RL10
      if (s2_read) begin
         dq_out_q <= rd_word; // RL11
      end
   end
end

assign dq_out = dq_out_q;
assign dq_oe = dq_oe_q;

endmodule // pbs_sram_port

// >>> tb/pbs_sram_port_chk.sv
`timescale 1ns/1ps
module pbs_chk (
   input wire ref_clk,
   input wire rst_b,
   input wire chip_select_one_n,
   input wire chip_select_two,
   input wire chip_select_three_n,
   input wire load_or_advance_n,
   input wire write_enable_n,
   input wire clock_gate_n,
   input wire [35:0] dq_out,
   input wire dq_oe,
   input wire write_buffer_ready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire run = !clock_gate_n;
   wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
   wire ld = run && sel && !load_or_advance_n;
   wire rd = ld && write_enable_n;
   wire wr = ld && !write_enable_n;
   wire adv = run && sel && load_or_advance_n;
   chk_read_late: assert property (rd ##1 run ##1 run |=> dq_oe)
      else $error("read not driven");
   chk_write_quiet: assert property (wr ##1 run ##1 run |=> !dq_oe)
      else $error("bus driven on write");
   chk_desel_hiz: assert property (run && !sel ##1 run ##1 run |=> !dq_oe)
      else $error("bus driven after deselect");
   chk_gate_hold: assert property (!run |=> $stable(dq_oe) && $stable(dq_out))
      else $error("output moved on gated edge");
   chk_adv_idle: assert property (run && !sel ##1 adv [*3] |=> !dq_oe)
      else $error("burst outlived deselect");
   chk_rd_burst: assert property (rd ##1 adv ##1 adv ##1 run ##1 run |=> dq_oe)
      else $error("read burst beat lost");
   chk_wr_burst: assert property (wr ##1 adv ##1 adv ##1 run ##1 run |=> !dq_oe)
      else $error("write burst turned read");
   chk_load_ends: assert property (rd ##1 wr ##1 run ##1 run |=> !dq_oe)
      else $error("load kept old burst");
   chk_buf_room: assert property (wr ##1 run |=> write_buffer_ready)
      else $error("write beat met a full buffer");
   cover property (rd ##1 adv [*3]);
   cover property (wr ##1 rd);
   cover property (!run ##1 run);
endmodule // pbs_chk

bind pbs_sram_port pbs_chk pbs_chk_inst (.ref_clk, .rst_b, .chip_select_one_n, .chip_select_two,
   .chip_select_three_n, .load_or_advance_n, .write_enable_n, .clock_gate_n, .dq_out, .dq_oe,
   .write_buffer_ready);

// >>> tb/pbs_ctl_model.sv
`timescale 1ns/1ps
module pbs_ctl_model (
   input wire ref_clk,
   input wire [35:0] dq_out,
   input wire dq_oe,
   output reg [17:0] addr,
   output reg chip_select_one_n,
   output reg chip_select_two,
   output reg chip_select_three_n,
   output reg load_or_advance_n,
   output reg write_enable_n,
   output reg [3:0] byte_lane_write_n,
   output reg clock_gate_n,
   output reg [35:0] dq_in
);
   reg bw, w1, w2, os;
   reg [3:0] l1;
   reg [35:0] d1, d2, qs;
   initial begin
      {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h4;
      {addr, load_or_advance_n, write_enable_n, clock_gate_n, dq_in, bw, w1, w2} = 0;
      byte_lane_write_n = 4'hF;
   end
   // Kinds: 0 deselected read load (a picks the idle select), 1 read, 2 write, 3 advance
   task step(input [1:0] k, input [17:0] a, input [35:0] d, input [3:0] ln);
      begin
         @(negedge ref_clk);
         qs = dq_out;
         os = dq_oe;
         @(posedge ref_clk);
         {chip_select_one_n, chip_select_two, chip_select_three_n} <= (k == 0) ? 3'h2 ^ a[2:0] : 3'h2;
         load_or_advance_n <= (k == 3);
         write_enable_n <= (k == 3) ? bw : (k != 2);
         addr <= a;
         clock_gate_n <= 1'h0;
         // Lanes and data of non-write beats are driven inverted from the values given for that beat
         byte_lane_write_n <= w1 ? l1 : ~l1;
         dq_in <= w2 ? d2 : ~d2;
         w2 = w1;
         d2 = d1;
         w1 = (k == 2) || (k == 3 && bw);
         l1 = ln;
         d1 = d;
         if (k != 3) bw = (k == 2);
      end
   endtask
   task hold;
      @(posedge ref_clk) clock_gate_n <= 1'h1;
   endtask
endmodule // pbs_ctl_model

// >>> tb/pbs_sram_port_tb.sv
`timescale 1ns/1ps
module pbs_sram_port_tb;
   reg ref_clk, rst_b, burst_order_interleaved;
   wire [17:0] addr;
   wire [3:0] byte_lane_write_n;
   wire [35:0] dq_in, dq_out;
   wire chip_select_one_n, chip_select_two, chip_select_three_n, load_or_advance_n, write_enable_n;
   wire clock_gate_n, dq_oe, write_buffer_ready;
   reg [35:0] em [0:31];
   reg [143:0] px;
   reg [3:0] pv;
   reg [1:0] bk;
   integer errors, samples_checked, i;
   pbs_sram_port pbs_sram_port_inst (.ref_clk, .rst_b, .addr, .chip_select_one_n, .chip_select_two,
      .chip_select_three_n, .load_or_advance_n, .write_enable_n, .byte_lane_write_n, .clock_gate_n,
      .burst_order_interleaved, .dq_in, .dq_out, .dq_oe, .write_buffer_ready);
   pbs_ctl_model pbs_ctl_model_inst (.ref_clk, .dq_out, .dq_oe, .addr, .chip_select_one_n, .chip_select_two,
      .chip_select_three_n, .load_or_advance_n, .write_enable_n, .byte_lane_write_n, .clock_gate_n, .dq_in);
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task chk(input [35:0] seen, input [35:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   function [1:0] ord(input m, input [1:0] s, input [1:0] n);
      ord = m ? s ^ n : s + n;
   endfunction
   function [35:0] mg(input [35:0] o, input [35:0] n, input [3:0] ln);
      integer j;
      begin
         mg = o;
         for (j = 0; j < 4; j++) if (!ln[j]) mg[j*9 +: 9] = n[j*9 +: 9];
      end
   endfunction
   // One bus cycle; read beats come back four calls later, gated edges not counted
   task b(input [1:0] k, input [17:0] a, input [35:0] d, input [3:0] ln);
      begin
         pbs_ctl_model_inst.step(k, a, d, ln);
         chk({35'h0, pbs_ctl_model_inst.os}, {35'h0, pv[3]});
         if (pv[3]) chk(pbs_ctl_model_inst.qs, px[143:108]);
         bk = (k == 3) ? bk : k;
         if (bk == 2) em[a[4:0]] = mg(em[a[4:0]], d, ln);
         pv = {pv[2:0], bk == 2'h1};
         px = {px[107:0], em[a[4:0]]};
      end
   endtask
   task idle(input integer n);
      repeat (n) b(0, 4, 0, 0);
   endtask
   task s_single;
      begin
         b(2, 5, 36'h123456789, 4'h0);
         b(1, 5, 0, 0);
         b(2, 5, 36'hFEDCBA987, 4'hA);
         b(1, 5, 0, 0);
         idle(4);
      end
   endtask
   task s_sel;
      begin
         for (i = 0; i < 3; i++) b(0, 18'h1 << i, 0, 0);
         repeat (3) b(3, 5, 0, 0);
         idle(4);
      end
   endtask
   task s_gate;
      begin
         b(1, 5, 0, 0);
         pbs_ctl_model_inst.hold;
         b(1, 5, 0, 0);
         pbs_ctl_model_inst.hold;
         pbs_ctl_model_inst.hold;
         idle(4);
      end
   endtask
   task s_burst(input m, input [1:0] s);
      begin
         burst_order_interleaved <= m;
         idle(3);
         for (i = 0; i < 4; i++) b(i ? 3 : 2, {16'h2, ord(m, s, i)}, {m, s, i[1:0], 31'h1234567}, 0);
         for (i = 0; i < 4; i++) b(i ? 3 : 1, {16'h2, ord(m, s, i)}, 0, 0);
         for (i = 0; i < 4; i++) b(1, {16'h2, i[1:0]}, 0, 0);
         idle(4);
      end
   endtask
   task conclude;
      begin
         $display("errors=%0d samples_checked=%0d", errors, samples_checked);
         if (errors == 0 && samples_checked > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors = errors + 1;
      conclude;
   end
   initial begin
      rst_b = 0;
      burst_order_interleaved = 0;
      errors = 0;
      samples_checked = 0;
      pv = 0;
      bk = 0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'h1;
      idle(2);
      s_single;
      s_sel;
      s_gate;
      s_burst(0, 2);
      s_burst(0, 1);
      s_burst(1, 2);
      s_burst(1, 1);
      conclude;
   end
endmodule // pbs_sram_port_tb
